// >>> pfs_defs.vh
// constants for the function status register block
`ifndef PFS_DEFS_VH
`define PFS_DEFS_VH

`define PFS_CMD_OFFSET      8'h04
`define PFS_STATUS_OFFSET   8'h06
`define PFS_STATUS_RESET    16'h0210

`define PFS_BIT_PAR_DET     15
`define PFS_BIT_SYS_SIG     14
`define PFS_BIT_RECEIVED_MASTER_ABORT_RX   13
`define PFS_BIT_TABORT_RX   12
`define PFS_BIT_TABORT_TX   11
`define PFS_BIT_DEVSEL_HI   10
`define PFS_BIT_DEVSEL_LO   9
`define PFS_BIT_MDPE        8
`define PFS_BIT_FB2B        7
`define PFS_BIT_UDF_SUP     6
`define PFS_BIT_HS_CAP      5
`define PFS_BIT_CAPABILITIES_LIST_PRESENT     4
`define PFS_BIT_INT_STAT    3

`define PFS_CMD_BIT_PERESP  6
`define PFS_CMD_BIT_SERREN  8
`define PFS_CMD_BIT_INTDIS  10
`define PFS_CMD_WMASK       16'h0540

`define PFS_DEVSEL_MEDIUM   2'h1
`define PFS_STICKY_MASK     16'hF900

`endif

// >>> pfs_sync.v
// two-flop synchroniser bank for asynchronous event and level inputs
`timescale 1ns/10ps
module pfs_sync #(
	parameter W = 8
) (
	input  wire         clk,
	input  wire         rst,
	input  wire         ce,
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);
	reg [W-1:0] stage1;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1 <= {W{1'b0}};
			dout   <= {W{1'b0}};
		end else if (ce) begin
			stage1 <= din;
			dout   <= stage1;
		end
	end
endmodule

// >>> pfs_status.v
// function status register with command enable bits and interrupt gating
// How it works
// - parity error detected sets bit 15
// - serr signaled while enabled sets bit 14
// - own master cycle master-aborted sets bit 13
// - own cycle target-aborted sets bit 12
// - we target-abort a transaction, set bit 11
// - bits 10:9 fixed 01b, medium devsel
// - bit 8: perr, we master, response enabled
// - bit 7 reads zero
// - bit 6 reads zero
// - bit 5 reads zero
// - bit 4 reads one
// - bit 3 pending irq; intx when not disabled
// - interrupt disable masks output only
// - reserved bits 2:0 read zero
// - serr driver enabled only by command bit 8
`timescale 1ns/10ps
`include "pfs_defs.vh"
module pfs_status (
	// clock and reset
	input  wire        CORE_CLK,
	input  wire        RST,
	input  wire        CE,
	// configuration register access
	input  wire [7:0]  CFG_ADDR,
	input  wire        CFG_WR,
	input  wire [1:0]  CFG_BE,
	input  wire [15:0] CFG_WDATA,
	output reg  [15:0] CFG_RDATA,
	// bus event pulses from the pci engine, same clock
	input  wire        ADDR_PARITY_ERR,
	input  wire        DATA_PARITY_ERR,
	input  wire        MASTER_ABORT_RX,
	input  wire        TARGET_ABORT_RX,
	input  wire        TARGET_ABORT_TX,
	input  wire        BUS_MASTER_ACTIVE,
	input  wire        SYSTEM_ERROR_REQ,
	// bus pin and function interrupt source, asynchronous
	input  wire        PERR_N_IN,
	input  wire        FUNC_IRQ,
	// outputs
	output reg         SERR_N_OUT,
	output reg         SERR_N_OE,
	output reg         INTX_N_OUT,
	output reg         INTX_N_OE,
	output wire        PARITY_RESPONSE_EN
);
	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	wire [1:0] synced;
	wire       perr_seen;
	wire       irq_pend;

	pfs_sync #(
		.W (2)
	) u_sync (
		.clk  (CORE_CLK),
		.rst  (RST),
		.ce   (CE),
		.din  ({~PERR_N_IN, FUNC_IRQ}),
		.dout (synced)
	);
	assign perr_seen = synced[1];
	assign irq_pend  = synced[0];

	// ------------------------------------------------------------
	// command enable bits
	// ------------------------------------------------------------
	reg  [15:0] cmd;
	wire        wr_cmd;
	wire        wr_stat;
	wire [15:0] be_mask;

	assign be_mask = {{8{CFG_BE[1]}}, {8{CFG_BE[0]}}};
	assign wr_cmd  = CFG_WR && (CFG_ADDR == `PFS_CMD_OFFSET);
	assign wr_stat = CFG_WR && (CFG_ADDR == `PFS_STATUS_OFFSET);
	assign PARITY_RESPONSE_EN = cmd[`PFS_CMD_BIT_PERESP];

	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			cmd <= 16'h0000;
		end else if (CE && wr_cmd) begin
			cmd <= (cmd & ~(`PFS_CMD_WMASK & be_mask)) | (CFG_WDATA & `PFS_CMD_WMASK & be_mask);
		end
	end

	// ------------------------------------------------------------
	// command fields used here
	// ------------------------------------------------------------
	// only the three bits this block acts on
	wire parity_response_enable;
	wire serr_driver_enable;
	wire int_disable;

	assign parity_response_enable = cmd[`PFS_CMD_BIT_PERESP];
	assign serr_driver_enable     = cmd[`PFS_CMD_BIT_SERREN];
	assign int_disable            = cmd[`PFS_CMD_BIT_INTDIS];

	// ------------------------------------------------------------
	// system error signalling
	// ------------------------------------------------------------
	// serr only after an address parity error or an explicit request
	wire serr_addr_parity;
	wire serr_request;
	wire serr_cause;
	wire serr_fire;
	reg  next_serr_n_out;
	reg  next_serr_n_oe;

	assign serr_addr_parity = ADDR_PARITY_ERR;
	assign serr_request     = SYSTEM_ERROR_REQ;
	assign serr_cause       = serr_addr_parity || serr_request;
	assign serr_fire        = serr_driver_enable && serr_cause;

	// driver stays off unless enabled, so the pin idles released
	always @* begin
		next_serr_n_out = 1'b1;
		next_serr_n_oe  = 1'b0;
		if (serr_fire) begin
			next_serr_n_out = 1'b0;
			next_serr_n_oe  = 1'b1;
		end
	end

	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			SERR_N_OUT <= 1'b1;
			SERR_N_OE  <= 1'b0;
		end else if (CE) begin
			SERR_N_OUT <= next_serr_n_out;
			SERR_N_OE  <= next_serr_n_oe;
		end
	end

	// ------------------------------------------------------------
	// flag set events
	// ------------------------------------------------------------
	// one-cycle pulses on this clock, except the synced pin
	wire        parity_event;
	wire        system_event;
	wire        received_master_abort_event;
	wire        tabort_rx_event;
	wire        tabort_tx_event;
	wire        master_perr_event;
	wire [15:0] ev;

	// address parity counts even while serr is disabled
	assign parity_event      = ADDR_PARITY_ERR || DATA_PARITY_ERR || perr_seen;
	assign system_event      = serr_fire;
	assign received_master_abort_event      = MASTER_ABORT_RX;
	assign tabort_rx_event   = TARGET_ABORT_RX;
	assign tabort_tx_event   = TARGET_ABORT_TX;
	// master state is taken live while the pin is two flops late
	assign master_perr_event = perr_seen && BUS_MASTER_ACTIVE && parity_response_enable;

	assign ev[15]   = parity_event;
	assign ev[14]   = system_event;
	assign ev[13]   = received_master_abort_event;
	assign ev[12]   = tabort_rx_event;
	assign ev[11]   = tabort_tx_event;
	assign ev[10:9] = 2'h0;
	assign ev[8]    = master_perr_event;
	assign ev[7:0]  = 8'h00;

	// ------------------------------------------------------------
	// write-one-to-clear decode
	// ------------------------------------------------------------
	// only sticky bits take a clear, fixed and live bits ignore writes
	wire        lane_lo;
	wire        lane_hi;
	wire [15:0] clr;

	assign lane_lo = wr_stat && CFG_BE[0];
	assign lane_hi = wr_stat && CFG_BE[1];
	assign clr     = {CFG_WDATA[15:8] & {8{lane_hi}}, CFG_WDATA[7:0] & {8{lane_lo}}} & `PFS_STICKY_MASK;

	// ------------------------------------------------------------
	// sticky error flags
	// ------------------------------------------------------------
	// set wins over a write-one clear in the same cycle
	wire [15:0] next_sticky;
	wire [15:0] sticky;

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_flag
			if (((`PFS_STICKY_MASK >> gi) & 16'h0001) != 16'h0000) begin : g_sticky
				reg flag;

				// event term ORed outside the clear, so a set and a clear together leave the flag set
				assign next_sticky[gi] = ev[gi] | (flag & ~clr[gi]);
				assign sticky[gi]      = flag;

				always @(posedge CORE_CLK or posedge RST) begin
					if (RST) begin
						flag <= 1'b0;
					end else if (CE) begin
						flag <= next_sticky[gi];
					end
				end
			end else begin : g_fixed
				// fixed and live bits hold no state here
				assign next_sticky[gi] = 1'b0;
				assign sticky[gi]      = 1'b0;
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// status word
	// ------------------------------------------------------------
	wire [4:0]  err_high;
	wire [1:0]  devsel_timing;
	wire        master_perr_flag;
	wire        fast_b2b_capable;
	wire        user_features_supported;
	wire        high_speed_capable;
	wire        capabilities_list_present;
	wire        int_status;
	wire [15:0] status;

	assign err_high                  = sticky[15:11];
	assign devsel_timing             = `PFS_DEVSEL_MEDIUM;
	assign master_perr_flag          = sticky[8];
	assign fast_b2b_capable          = 1'b0;
	assign user_features_supported   = 1'b0;
	assign high_speed_capable        = 1'b0;
	assign capabilities_list_present = 1'b1;
	// live level from the synced source, the disable bit never touches it
	assign int_status                = irq_pend;

	// fields in the order the host reads them
	assign status[15:11] = err_high;
	assign status[10:9]  = devsel_timing;
	assign status[8]     = master_perr_flag;
	assign status[7]     = fast_b2b_capable;
	assign status[6]     = user_features_supported;
	assign status[5]     = high_speed_capable;
	assign status[4]     = capabilities_list_present;
	assign status[3]     = int_status;
	assign status[2:0]   = 3'h0;

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	// registered so the host sees a value that cannot glitch mid-cycle
	wire        rd_cmd;
	wire        rd_stat;
	reg  [15:0] next_rdata;

	assign rd_cmd  = (CFG_ADDR == `PFS_CMD_OFFSET);
	assign rd_stat = (CFG_ADDR == `PFS_STATUS_OFFSET);

	// other offsets read zero
	always @* begin
		next_rdata = 16'h0000;
		if (rd_cmd) begin
			next_rdata = cmd;
		end else if (rd_stat) begin
			next_rdata = status;
		end
	end

	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			CFG_RDATA <= 16'h0000;
		end else if (CE) begin
			CFG_RDATA <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// interrupt pin
	// ------------------------------------------------------------
	// the disable bit gates only the pin, never the status bit
	wire int_enable;
	wire int_drive;
	reg  next_intx_n_out;
	reg  next_intx_n_oe;

	assign int_enable = !int_disable;
	assign int_drive  = int_status && int_enable;

	always @* begin
		next_intx_n_out = 1'b1;
		next_intx_n_oe  = 1'b0;
		if (int_drive) begin
			next_intx_n_out = 1'b0;
			next_intx_n_oe  = 1'b1;
		end
	end

	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			INTX_N_OUT <= 1'b1;
			INTX_N_OE  <= 1'b0;
		end else if (CE) begin
			INTX_N_OUT <= next_intx_n_out;
			INTX_N_OE  <= next_intx_n_oe;
		end
	end
endmodule

// >>> pfs_status_sva.sv
// assertion checker for the status register ports
`timescale 1ns/10ps
module pfs_status_sva (
	// clock and reset
	input logic        CORE_CLK,
	input logic        RST,
	// register access
	input logic        CFG_WR,
	input logic [1:0]  CFG_BE,
	input logic [7:0]  CFG_ADDR,
	input logic [15:0] CFG_WDATA,
	input logic [15:0] CFG_RDATA,
	// events and sources
	input logic        FUNC_IRQ,
	input logic        DATA_PARITY_ERR,
	input logic        MASTER_ABORT_RX,
	input logic        ADDR_PARITY_ERR,
	input logic        SYSTEM_ERROR_REQ,
	// pins
	input logic        SERR_N_OUT,
	input logic        SERR_N_OE,
	input logic        INTX_N_OUT,
	input logic        INTX_N_OE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// status read with no write in the same cycle
	wire st = CFG_ADDR == 8'h06 && !CFG_WR;
	AST_DEVSEL: assert property ($past(st) && !$past(RST) |-> CFG_RDATA[10:9] == 2'h1)
		else $error("devsel");
	AST_FIXED: assert property ($past(st) && !$past(RST) |-> CFG_RDATA[7:4] == 4'h1)
		else $error("caps");
	AST_RSVD: assert property ($past(st) && !$past(RST) |-> CFG_RDATA[2:0] == 3'h0)
		else $error("reserved");
	AST_PAR: assert property (DATA_PARITY_ERR ##1 st |=> CFG_RDATA[15])
		else $error("parity");
	AST_RECEIVED_MASTER_ABORT: assert property (MASTER_ABORT_RX ##1 st |=> CFG_RDATA[13])
		else $error("received_master_abort");
	AST_CLEAR: assert property (CFG_WR && CFG_ADDR == 8'h06 && CFG_BE[1] && CFG_WDATA[13] && !MASTER_ABORT_RX ##1 st && !MASTER_ABORT_RX |=> !CFG_RDATA[13])
		else $error("clear");
	AST_SERR: assert property (SERR_N_OE |-> !SERR_N_OUT && $past(ADDR_PARITY_ERR || SYSTEM_ERROR_REQ))
		else $error("serr");
	AST_INTX: assert property (INTX_N_OE |-> !INTX_N_OUT && $past(FUNC_IRQ, 3))
		else $error("intx");
endmodule
bind pfs_status pfs_status_sva chk (.*);

// >>> pfs_far.sv
// far side model: parity pin and interrupt source
`timescale 1ns/10ps
module pfs_far (
	input  wire clk,
	output reg  perr_n = 1'b1,
	output reg  irq = 1'b0
);
	// pin is active low, so the task drives it low for n negedges, then back high
	task perr(input integer n);
		perr_n = 1'b0;
		repeat (n) @(negedge clk);
		perr_n = 1'b1;
	endtask
	task level(input v);
		irq = v;
	endtask
endmodule

// >>> tb_top.sv
// self-checking bench for the function status register
`timescale 1ns/10ps
module tb_top;
	reg         CORE_CLK = 1'b0, RST = 1'b1, CFG_WR = 1'b0, BUS_MASTER_ACTIVE = 1'b1;
	reg  [1:0]  CFG_BE = 2'h3;
	reg  [5:0]  ev = 6'h00;
	reg  [7:0]  CFG_ADDR = 8'h00;
	reg  [15:0] CFG_WDATA = 16'h0000;
	wire [15:0] CFG_RDATA;
	reg         CE = 1'b1;
	wire        ADDR_PARITY_ERR = ev[5], DATA_PARITY_ERR = ev[4], MASTER_ABORT_RX = ev[3];
	wire        TARGET_ABORT_RX = ev[2], TARGET_ABORT_TX = ev[1], SYSTEM_ERROR_REQ = ev[0];
	wire        PERR_N_IN, FUNC_IRQ, SERR_N_OUT, SERR_N_OE, INTX_N_OUT, INTX_N_OE, PARITY_RESPONSE_EN;
	integer     num_errors = 0, num_checks = 0, i;
	always #25 CORE_CLK = ~CORE_CLK;
	pfs_status uut (.*);
	pfs_far far (.clk(CORE_CLK), .perr_n(PERR_N_IN), .irq(FUNC_IRQ));
	task chk(input [63:0] name, input [15:0] seen, input [15:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("[ERR] %0s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wr(input [7:0] a, input [15:0] d);
		CFG_ADDR = a;
		CFG_WDATA = d;
		CFG_WR = 1'b1;
		@(negedge CORE_CLK);
		CFG_WR = 1'b0;
	endtask
	task rd(input [7:0] a, input [15:0] e);
		CFG_ADDR = a;
		@(negedge CORE_CLK);
		chk("rdata", CFG_RDATA, e);
	endtask
	task pulse(input [5:0] v);
		ev = v;
		@(negedge CORE_CLK);
		ev = 6'h00;
	endtask
	task close_out;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// about 2000 cycles, well past the sequence length
	initial begin
		#100000;
		num_errors = num_errors + 1;
		close_out;
	end
	initial begin
		repeat (3) @(negedge CORE_CLK);
		RST = 1'b0;
		rd(8'h06, 16'h0210);
		wr(8'h06, 16'hFFFF);
		rd(8'h06, 16'h0210);
		rd(8'h00, 16'h0000);
		for (i = 1; i < 4; i = i + 1) begin
			pulse(6'h01 << i);
			rd(8'h06, 16'h0210 | (16'h0400 << i));
			wr(8'h06, 16'h0000);
			rd(8'h06, 16'h0210 | (16'h0400 << i));
			wr(8'h06, 16'h0400 << i);
			rd(8'h06, 16'h0210);
		end
		pulse(6'h08);
		CFG_BE = 2'h1;
		wr(8'h06, 16'h2000);
		CFG_BE = 2'h3;
		rd(8'h06, 16'h2210);
		wr(8'h06, 16'h2000);
		rd(8'h06, 16'h0210);
		wr(8'h04, 16'hFFFF);
		rd(8'h04, 16'h0540);
		chk("pr_en", PARITY_RESPONSE_EN, 16'h0001);
		pulse(6'h10);
		chk("serr", {SERR_N_OE, SERR_N_OUT}, 16'h0001);
		rd(8'h06, 16'h8210);
		wr(8'h06, 16'h8000);
		pulse(6'h20);
		chk("serr", {SERR_N_OE, SERR_N_OUT}, 16'h0002);
		rd(8'h06, 16'hC210);
		wr(8'h06, 16'hC000);
		pulse(6'h01);
		rd(8'h06, 16'h4210);
		wr(8'h06, 16'h4000);
		far.perr(1);
		repeat (3) @(negedge CORE_CLK);
		rd(8'h06, 16'h8310);
		wr(8'h06, 16'h8100);
		BUS_MASTER_ACTIVE = 1'b0;
		far.perr(2);
		repeat (3) @(negedge CORE_CLK);
		rd(8'h06, 16'h8210);
		wr(8'h06, 16'h8000);
		far.level(1'b1);
		repeat (4) @(negedge CORE_CLK);
		chk("intx", {INTX_N_OE, INTX_N_OUT}, 16'h0001);
		rd(8'h06, 16'h0218);
		wr(8'h04, 16'h0000);
		pulse(6'h21);
		chk("serr", {SERR_N_OE, SERR_N_OUT}, 16'h0001);
		chk("intx", {INTX_N_OE, INTX_N_OUT}, 16'h0002);
		chk("pr_en", PARITY_RESPONSE_EN, 16'h0000);
		rd(8'h06, 16'h8218);
		CE = 1'b0;
		pulse(6'h08);
		CE = 1'b1;
		rd(8'h06, 16'h8218);
		far.level(1'b0);
		RST = 1'b1;
		@(negedge CORE_CLK);
		RST = 1'b0;
		rd(8'h06, 16'h0210);
		rd(8'h04, 16'h0000);
		close_out;
	end
endmodule
